// file: design/serial_pkg.sv
package serial_pkg;
    // Register byte addresses
    localparam logic [15:0] ADDR_ASYNC = 16'hff70;
    localparam logic [15:0] ADDR_ERR = 16'hff71;
    localparam logic [15:0] ADDR_SYNC = 16'hff72;
    localparam logic [15:0] ADDR_BAUD = 16'hff73;
    localparam logic [15:0] ADDR_DATA = 16'hff74;
    // Reset value and writable-bit masks
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] ASYNC_MASK = 8'hfc;
    localparam logic [7:0] SYNC_MASK = 8'hcf;
    localparam logic [7:0] BAUD_MASK = 8'hf0;
    // Async mode bits
    localparam int TXE_BIT = 7;
    localparam int RXE_BIT = 6;
    localparam int PAR_HI = 5;
    localparam int PAR_LO = 4;
    localparam int CLEN_BIT = 3;
    localparam int STOP_BIT = 2;
    // Sync mode bits
    localparam int CSI_EN_BIT = 7;
    localparam int SSEL_BIT = 6;
    localparam int PHASE_BIT = 3;
    localparam int ORDER_BIT = 2;
    localparam int CSRC_BIT = 1;
    localparam int CPOL_BIT = 0;
    // Baud control source field
    localparam int SRC_HI = 7;
    localparam int SRC_LO = 4;
    localparam logic [3:0] SRC_EXT = 4'h8;
    localparam logic [3:0] SRC_MAX_DIV = 4'h7;
    // Parity encodings
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ZERO = 2'h1;
    localparam logic [1:0] PAR_ODD = 2'h2;
    // Frame sizes, oversampling phases
    localparam logic [3:0] LEN7 = 4'h7;
    localparam logic [3:0] LEN8 = 4'h8;
    localparam logic [3:0] ONE_BIT = 4'h1;
    localparam logic [3:0] TWO_BITS = 4'h2;
    localparam logic [3:0] OVS_MID = 4'h7;
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] CSI_BITS = 4'h8;
    // Transmitter states
    typedef enum logic {
        TX_IDLE = 1'b0,
        TX_SEND = 1'b1
    } tx_state_t;
    // Receiver states
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } rx_state_t;
endpackage

// file: design/baud_tick_if.sv
interface baud_tick_if;
    logic [3:0] srcSel; // Source field of baud control
    logic extPin; // External baud clock level
    logic tick; // One pulse per source period
    modport gen (input srcSel, input extPin, output tick);
    modport user (output srcSel, output extPin, input tick);
endinterface

// file: design/baud_gen.sv
module baud_gen (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Rate control and tick
    baud_tick_if.gen bt
);
    // Whole state of the divider
    typedef struct packed {
        logic [7:0] cnt; // Free prescaler
        logic extPrev; // Last external level
        logic tick; // Registered tick
    } gen_state_t;

    gen_state_t q, d;
    logic [8:0] span; // Period minus one, per code

    assign bt.tick = q.tick;

    // Next-state: divide by 2^(n+1) or count pin edges
    always_comb begin
        d = q;
        span = (9'h002 << bt.srcSel[2:0]) - 9'h001;
        d.cnt = q.cnt + 8'h01;
        d.extPrev = bt.extPin;
        d.tick = 1'b0;
        if (bt.srcSel == serial_pkg::SRC_EXT) begin
            // Every pin rise is one 16x tick, so bit = pin/16 [R1] [R2] [R10]
            d.tick = bt.extPin && !q.extPrev;
        end else if (bt.srcSel <= serial_pkg::SRC_MAX_DIV) begin
            // Tick at fx/2^(n+1); toggling on it gives fx/2^(n+2) [R3] [R21]
            d.tick = (q.cnt & span[7:0]) == span[7:0];
        end
        // Prohibited codes give no tick at all [R21]
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

// file: design/dual_mode_serial.sv
// Functional notes
// R1: External baud pin divided by sixteen
// R2: Source code 80h selects external pin
// R3: Internal 3-wire clock is fx/2^(n+1); the generated clock here is fx/2^(n+2)
// R4: Baud control unneeded with external clock
// R5: Three modes: stopped, async, 3-wire
// R6: Stopped mode: no transfer, pins released
// R7: Stopped when all three enables zero
// R8: Sync bit 7 enables 3-wire mode
// R9: Async start plus character, full duplex
// R10: 31.25 kbps rate, 500 kHz pin
// R11: Sync register zero during async use
// R12: Select pin gates 3-wire when used
// R13: Data phase edge and first bit order
// R14: Bit 1 picks external or generated clock
// R15: Bit 0 sets clock idle level
// R16: Reserved mode bits kept zero
// R17: Halt transfers before changing mode
// R18: Parity none, zero, odd, even
// R19: Seven/eight data bits, one/two stops
// R20: Receiver checks a single stop bit
// R21: Source field divides fx or picks pin
// R22: Overrun when unread buffer is overwritten
// R23: Sixteen-times clock, mid-bit sampling
// R24: Async line idles high, start low
module dual_mode_serial (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Register port
    input wire logic [15:0] regAddr,
    input wire logic regWr,
    input wire logic [7:0] regWrData,
    input wire logic regRd,
    output logic [7:0] regRdData,
    // Link pins
    input wire logic extBaudClockPin,
    input wire logic serialClockPinIn,
    output logic serialClockPinOut,
    output logic serialClockPinOe,
    input wire logic serialInPin,
    output logic serialOutPin,
    output logic serialOutOe,
    input wire logic slaveSelectPin
);
    // Whole state of the block
    typedef struct packed {
        logic [7:0] asim; // Async mode control
        logic [7:0] csim; // Sync mode control
        logic [7:0] brgc; // Baud generator control
        logic [7:0] rxBuf; // Receive buffer
        logic [7:0] rdData; // Read answer
        logic rxFull; // Unread character held
        logic pe; // Parity error
        logic fe; // Framing error
        logic ove; // Overrun error
        serial_pkg::tx_state_t txSt;
        logic [11:0] txSh; // Outgoing frame, LSB first
        logic [3:0] txBits; // Frame bits left
        logic [3:0] txPh; // 16x phase
        serial_pkg::rx_state_t rxSt;
        logic [3:0] rxPh; // 16x phase
        logic [3:0] rxCnt; // Data+parity bits left
        logic [8:0] rxSh; // Incoming bits
        logic csiBusy; // 3-wire transfer running
        logic [3:0] csiCnt; // Bits left to sample
        logic [7:0] csiSh; // 3-wire shifter
        logic csiOut; // Bit on the output
        logic sckLvl; // Generated clock level
        logic sckPrev; // Last external clock
        logic serOut;
        logic serOe;
        logic sckOut;
        logic sckOe;
    } state_t;

    state_t q, d;
    baud_tick_if bt ();

    // Decoded modes and helpers
    logic uartOn, csiOn, ssOk, len8, tick;
    logic [1:0] par;
    logic [7:0] dBits, rxData;
    logic pBit, rxPar, oldLvl, newLvl;
    logic rise, fall, smpEdge, shfEdge;
    logic [8:0] rxAll;
    logic [3:0] nData;
    logic rxDone, csiDone;

    assign bt.srcSel = q.brgc[serial_pkg::SRC_HI:serial_pkg::SRC_LO];
    assign bt.extPin = extBaudClockPin;
    assign tick = bt.tick;

    // Rate tick: fx/2^(n+1) or pin edges
    baud_gen u_baud (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .bt(bt)
    );

    // Outputs straight from the state register
    assign regRdData = q.rdData;
    assign serialOutPin = q.serOut;
    assign serialOutOe = q.serOe;
    assign serialClockPinOut = q.sckOut;
    assign serialClockPinOe = q.sckOe;

    // Next-state logic
    always_comb begin
        d = q;
        rxDone = 1'b0;
        csiDone = 1'b0;
        // 3-wire wins over async; all off means stopped [R5] [R7] [R8]
        csiOn = q.csim[serial_pkg::CSI_EN_BIT];
        uartOn = !csiOn && (q.asim[serial_pkg::TXE_BIT]
            || q.asim[serial_pkg::RXE_BIT]); // [R9]
        // Select pin only gates when its use is on [R12]
        ssOk = !q.csim[serial_pkg::SSEL_BIT] || !slaveSelectPin;
        len8 = q.asim[serial_pkg::CLEN_BIT];
        par = q.asim[serial_pkg::PAR_HI:serial_pkg::PAR_LO];
        nData = (len8 ? serial_pkg::LEN8 : serial_pkg::LEN7)
            + {3'h0, par != serial_pkg::PAR_NONE};
        dBits = len8 ? regWrData : {1'b0, regWrData[6:0]};
        // Parity of outgoing data [R18]
        if (par == serial_pkg::PAR_ZERO) begin
            pBit = 1'b0;
        end else if (par == serial_pkg::PAR_ODD) begin
            pBit = ~^dBits;
        end else begin
            pBit = ^dBits;
        end
        rxAll = q.rxSh >> (4'h9 - nData);
        rxData = len8 ? rxAll[7:0] : {1'b0, rxAll[6:0]};
        rxPar = len8 ? rxAll[8] : rxAll[7];

        // Register reads; buffer read frees it
        if (regRd) begin
            case (regAddr)
                serial_pkg::ADDR_ASYNC: d.rdData = q.asim;
                serial_pkg::ADDR_ERR: d.rdData = {5'h00, q.pe, q.fe, q.ove};
                serial_pkg::ADDR_SYNC: d.rdData = q.csim;
                serial_pkg::ADDR_BAUD: d.rdData = q.brgc;
                serial_pkg::ADDR_DATA: begin
                    d.rdData = q.rxBuf;
                    d.rxFull = 1'b0;
                    d.ove = 1'b0;
                end
                default: d.rdData = serial_pkg::REG_RESET;
            endcase
        end

        // Register writes; reserved bits held at zero [R16]
        if (regWr) begin
            case (regAddr)
                serial_pkg::ADDR_ASYNC: begin
                    d.asim = regWrData & serial_pkg::ASYNC_MASK;
                end
                serial_pkg::ADDR_SYNC: begin
                    d.csim = regWrData & serial_pkg::SYNC_MASK;
                end
                serial_pkg::ADDR_BAUD: begin
                    d.brgc = regWrData & serial_pkg::BAUD_MASK;
                end
                default: begin
                end
            endcase
        end

        // Transmit load: start low, data, parity, stops high [R9] [R24]
        if (regWr && regAddr == serial_pkg::ADDR_DATA && uartOn
                && q.asim[serial_pkg::TXE_BIT] && q.txSt == serial_pkg::TX_IDLE)
        begin
            d.txSh = '1;
            d.txSh[8:0] = {dBits, 1'b0};
            // 7-bit frames: the slot after the data is the first stop, or the parity bit
            if (!len8) begin
                d.txSh[serial_pkg::LEN8] = 1'b1;
            end
            if (par != serial_pkg::PAR_NONE) begin
                d.txSh[nData] = pBit; // [R18]
            end
            // Stop count from its length bit [R19]
            d.txBits = ONE_OR_TWO(q.asim[serial_pkg::STOP_BIT])
                + nData + serial_pkg::ONE_BIT;
            d.txPh = '0;
            d.txSt = serial_pkg::TX_SEND;
        end else if (q.txSt == serial_pkg::TX_SEND && tick) begin
            // Sixteen ticks per bit [R1] [R23]
            d.txPh = q.txPh + 4'h1;
            if (q.txPh == serial_pkg::OVS_LAST) begin
                d.txSh = {1'b1, q.txSh[11:1]};
                d.txBits = q.txBits - 4'h1;
                if (q.txBits == serial_pkg::ONE_BIT) begin
                    d.txSt = serial_pkg::TX_IDLE;
                end
            end
        end
        if (!uartOn || !q.asim[serial_pkg::TXE_BIT]) begin
            d.txSt = serial_pkg::TX_IDLE;
        end

        // Receiver: find start edge, sample mid-bit [R23]
        if (!uartOn || !q.asim[serial_pkg::RXE_BIT]) begin
            d.rxSt = serial_pkg::RX_IDLE;
        end else if (tick) begin
            d.rxPh = q.rxPh + 4'h1;
            case (q.rxSt)
                serial_pkg::RX_IDLE: begin
                    d.rxPh = '0;
                    if (!serialInPin) begin
                        d.rxSt = serial_pkg::RX_START; // [R24]
                    end
                end
                serial_pkg::RX_START: begin
                    if (q.rxPh == serial_pkg::OVS_MID) begin
                        d.rxPh = '0;
                        d.rxCnt = nData;
                        // Glitch shorter than half a bit is dropped
                        d.rxSt = serialInPin ? serial_pkg::RX_IDLE
                            : serial_pkg::RX_DATA;
                    end
                end
                serial_pkg::RX_DATA: begin
                    if (q.rxPh == serial_pkg::OVS_LAST) begin
                        d.rxSh = {serialInPin, q.rxSh[8:1]};
                        d.rxCnt = q.rxCnt - 4'h1;
                        if (q.rxCnt == serial_pkg::ONE_BIT) begin
                            d.rxSt = serial_pkg::RX_STOP;
                        end
                    end
                end
                serial_pkg::RX_STOP: begin
                    // Only the first stop bit is looked at [R20]
                    if (q.rxPh == serial_pkg::OVS_LAST) begin
                        rxDone = 1'b1;
                        d.rxSt = serial_pkg::RX_IDLE;
                        d.rxBuf = rxData;
                        d.fe = !serialInPin;
                        // Zero-parity mode never flags [R18]
                        d.pe = par[1] && ((^rxData ^ rxPar)
                            != (par == serial_pkg::PAR_ODD));
                    end
                end
                default: d.rxSt = serial_pkg::RX_IDLE;
            endcase
        end

        // 3-wire clock: pin or generator [R14]
        oldLvl = q.csim[serial_pkg::CSRC_BIT] ? q.sckLvl : q.sckPrev;
        newLvl = q.csim[serial_pkg::CSRC_BIT]
            ? (q.sckLvl ^ (tick && q.csiBusy && ssOk)) // [R3]
            : serialClockPinIn;
        d.sckPrev = serialClockPinIn;
        d.sckLvl = newLvl;
        rise = newLvl && !oldLvl;
        fall = !newLvl && oldLvl;
        // Phase bit picks the output edge [R13]
        shfEdge = q.csim[serial_pkg::PHASE_BIT] ? rise : fall;
        smpEdge = q.csim[serial_pkg::PHASE_BIT] ? fall : rise;

        // 3-wire transfer
        if (!csiOn) begin
            d.csiBusy = 1'b0;
        end else if (regWr && regAddr == serial_pkg::ADDR_DATA
                && !q.csiBusy) begin
            d.csiBusy = 1'b1;
            d.csiSh = regWrData;
            d.csiCnt = serial_pkg::CSI_BITS;
            // First bit from order bit [R13]
            d.csiOut = q.csim[serial_pkg::ORDER_BIT] ? regWrData[0]
                : regWrData[7];
        end else if (q.csiBusy && ssOk) begin // [R12]
            if (smpEdge) begin
                d.csiSh = q.csim[serial_pkg::ORDER_BIT]
                    ? {serialInPin, q.csiSh[7:1]}
                    : {q.csiSh[6:0], serialInPin};
                d.csiCnt = q.csiCnt - 4'h1;
                if (q.csiCnt == serial_pkg::ONE_BIT) begin
                    csiDone = 1'b1;
                    d.csiBusy = 1'b0;
                    d.rxBuf = d.csiSh;
                end
            end else if (shfEdge && q.csiCnt != serial_pkg::CSI_BITS) begin
                d.csiOut = q.csim[serial_pkg::ORDER_BIT] ? q.csiSh[0]
                    : q.csiSh[7];
            end
        end
        // Idle level from polarity bit; the last sample edge still
        // reaches the pin for one cycle [R15]
        if (!d.csiBusy && !csiDone) begin
            d.sckLvl = !q.csim[serial_pkg::CPOL_BIT];
        end

        // Completion beats a same-cycle buffer read [R22]
        if (rxDone || csiDone) begin
            d.ove = q.rxFull;
            d.rxFull = 1'b1;
        end

        // Pins: released in stopped mode [R6]
        d.serOe = uartOn ? q.asim[serial_pkg::TXE_BIT] : (csiOn && ssOk);
        if (uartOn) begin
            d.serOut = (d.txSt == serial_pkg::TX_SEND) ? d.txSh[0] : 1'b1;
        end else begin
            d.serOut = csiOn ? d.csiOut : 1'b1;
        end
        d.sckOe = csiOn && q.csim[serial_pkg::CSRC_BIT]; // [R14]
        d.sckOut = d.sckLvl;
    end

    // One or two stop bits
    function automatic logic [3:0] ONE_OR_TWO(input logic two);
        ONE_OR_TWO = two ? serial_pkg::TWO_BITS : serial_pkg::ONE_BIT;
    endfunction

    // State register, synchronous reset
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence sTxLoad;
        q.txSt == serial_pkg::TX_IDLE && d.txSt == serial_pkg::TX_SEND;
    endsequence

    sequence sStartOut;
        !serialOutPin && serialOutOe;
    endsequence

    a_stop_pins_free: assert property ( // [R6]
        (!uartOn && !csiOn) |=> !serialOutOe && !serialClockPinOe)
        else $error("pins driven in stopped mode");

    a_tx_start_low: assert property ( // [R24]
        sTxLoad |=> sStartOut)
        else $error("start bit not low");

    a_tx_idle_high: assert property ( // [R24]
        (uartOn && d.txSt == serial_pkg::TX_IDLE) |=> serialOutPin)
        else $error("async line not high when idle");

    a_tx_bit_time: assert property ( // [R23]
        (q.txSt == serial_pkg::TX_SEND
            && $past(q.txSt) == serial_pkg::TX_SEND
            && $changed(q.txBits))
        |-> $past(tick) && $past(q.txPh) == serial_pkg::OVS_LAST)
        else $error("tx bit moved off its sixteenth tick");

    a_mode_exclusive: assert property ( // [R5]
        q.csiBusy |-> q.txSt == serial_pkg::TX_IDLE
            && q.rxSt == serial_pkg::RX_IDLE)
        else $error("async and 3-wire active together");

    a_ss_freeze: assert property ( // [R12]
        (q.csiBusy && q.csim[serial_pkg::SSEL_BIT] && slaveSelectPin
            && !regWr && csiOn) |=> $stable(q.csiCnt))
        else $error("transfer moved while deselected");

    a_sck_gen_tick: assert property ( // [R3]
        (q.csiBusy && $past(q.csiBusy) && q.csim[serial_pkg::CSRC_BIT]
            && $changed(q.sckLvl)) |-> $past(tick))
        else $error("generated clock moved without tick");

    a_sck_idle_lvl: assert property ( // [R15]
        (csiOn && !q.csiBusy && !$past(q.csiBusy) && $stable(q.csim))
        |-> q.sckLvl == !q.csim[serial_pkg::CPOL_BIT])
        else $error("serial clock not at idle level");

    a_overrun_flag: assert property ( // [R22]
        ((rxDone || csiDone) && q.rxFull) |=> q.ove && q.rxFull)
        else $error("overrun not flagged");
endmodule

// file: tb/serial_partner.sv
module serial_partner (
    // Clock
    input wire logic clk_sys,
    // Line levels seen and driven
    input wire logic fromDut,
    input wire logic sclk,
    output logic toDut
);
    timeunit 1ns;
    timeprecision 100ps;

    // Released line rests high, as a pulled-up wire would
    initial toDut = 1'b1;

    // Send start low, then n bits LSB first, then release
    task automatic send_frame(input logic [11:0] bits, input int n,
        input int cyc);
        for (int i = -1; i < n; i++) begin
            toDut = (i < 0) ? 1'b0 : bits[i];
            repeat (cyc) @(posedge clk_sys);
            #1;
        end
        toDut = 1'b1;
    endtask

    // Find start, sample each later bit mid-period
    task automatic grab_frame(output logic [11:0] bits, input int cyc);
        int w;
        w = 0;
        while (fromDut !== 1'b0 && w < 400) begin
            @(posedge clk_sys);
            w++;
        end
        // Half a bit puts later samples near mid-bit
        repeat (cyc / 2) @(posedge clk_sys);
        for (int i = 0; i < 12; i++) begin
            repeat (cyc) @(posedge clk_sys);
            bits[i] = fromDut;
        end
    endtask

    // Bounded wait for a serial clock level
    task automatic wait_lvl(input logic lvl);
        int w;
        w = 0;
        while (sclk !== lvl && w < 200) begin
            @(posedge clk_sys);
            w++;
        end
    endtask

    // Clocked slave: sample on rising, change after falling
    task automatic shift_slave(input logic [7:0] give, input logic lsb,
        output logic [7:0] got);
        toDut = lsb ? give[0] : give[7];
        for (int i = 0; i < 8; i++) begin
            wait_lvl(1'b1);
            got[lsb ? i : 7 - i] = fromDut;
            wait_lvl(1'b0);
            #1;
            // Last bit has no successor
            if (i < 7) begin
                toDut = lsb ? give[i + 1] : give[6 - i];
            end
        end
        toDut = 1'b1;
    endtask
endmodule

// file: tb/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_sys = 1'b0; // System clock
    logic rstn = 1'b0; // Reset, low active
    logic [15:0] regAddr = 16'h0000;
    logic regWr = 1'b0;
    logic [7:0] regWrData = 8'h00;
    logic regRd = 1'b0;
    logic [7:0] regRdData;
    logic extBaudClockPin = 1'b0; // External rate pin
    logic extRun = 1'b0; // Runs the external pin
    logic [1:0] extDiv = 2'h0; // Pin divider
    logic serialClockPinOut, serialClockPinOe;
    logic serialInPin, serialOutPin, serialOutOe;
    logic slaveSelectPin = 1'b0; // Select input
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0; // Hang guard

    // 200 MHz clock
    always #2.5 clk_sys = ~clk_sys;

    // External pin at a quarter of the system rate; also the 3-wire clock
    always @(posedge clk_sys) begin
        #1;
        extDiv = extRun ? extDiv + 2'h1 : 2'h0;
        extBaudClockPin = extDiv[1];
    end

    // Cut a hang short; limit covers every scenario
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    dual_mode_serial dut (
        .clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr), .regWr(regWr),
        .regWrData(regWrData), .regRd(regRd), .regRdData(regRdData),
        .extBaudClockPin(extBaudClockPin),
        .serialClockPinIn(extBaudClockPin),
        .serialClockPinOut(serialClockPinOut),
        .serialClockPinOe(serialClockPinOe), .serialInPin(serialInPin),
        .serialOutPin(serialOutPin), .serialOutOe(serialOutOe),
        .slaveSelectPin(slaveSelectPin)
    );

    serial_partner partner (
        .clk_sys(clk_sys), .fromDut(serialOutPin),
        .sclk(serialClockPinOut), .toDut(serialInPin)
    );

    // Verdict in one place
    task automatic tally_and_finish();
        $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Compare and count
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask

    // One write; idle cycle keeps strobes apart
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        regAddr = a;
        regWrData = d;
        regWr = 1'b1;
        @(posedge clk_sys);
        #1;
        regWr = 1'b0;
        @(posedge clk_sys);
        #1;
    endtask

    // One read, answer checked
    task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
        regAddr = a;
        regRd = 1'b1;
        @(posedge clk_sys);
        #1;
        regRd = 1'b0;
        @(posedge clk_sys);
        #1;
        chk(regRdData, exp);
    endtask

    // Bits after start: data LSB first, parity, then high
    function automatic logic [11:0] frame(logic [7:0] d, logic l8,
        logic [1:0] pm);
        logic [11:0] f;
        logic p;
        int n;
        f = '1;
        n = l8 ? 8 : 7;
        p = ^(l8 ? d : {1'b0, d[6:0]});
        for (int i = 0; i < n; i++) f[i] = d[i];
        if (pm != 2'h0) f[n] = (pm == 2'h1) ? 1'b0 : (pm == 2'h2) ? ~p : p;
        return f;
    endfunction

    // Reset values, masks, unmapped place, pins released
    task automatic t_regs();
        chk(serialOutOe, 1'b0);
        chk(serialClockPinOe, 1'b0);
        rchk(16'hff70, 8'h00);
        rchk(16'hff72, 8'h00);
        rchk(16'hff73, 8'h00);
        wr(16'hff70, 8'hff);
        rchk(16'hff70, 8'hfc);
        wr(16'hff72, 8'hff);
        rchk(16'hff72, 8'hcf);
        wr(16'hff72, 8'h00);
        wr(16'hff73, 8'hff);
        rchk(16'hff73, 8'hf0);
        rchk(16'hff7f, 8'h00);
    endtask

    // Each parity mode, then 7 bits with two stops
    task automatic t_async_tx();
        logic [11:0] got;
        wr(16'hff73, 8'h00);
        for (int m = 0; m < 5; m++) begin
            wr(16'hff70, (m < 4) ? {4'h8 | m[1:0], 4'h8} : 8'h84);
            chk(serialOutOe, 1'b1);
            fork
                partner.grab_frame(got, 32);
                wr(16'hff74, 8'hd3);
            join
            chk(got, frame(8'hd3, m < 4, m[1:0]));
        end
        wr(16'hff70, 8'h00);
        chk(serialOutOe, 1'b0);
    endtask

    // Back to back single-stop frames, then error flags
    task automatic t_async_rx();
        logic [11:0] f;
        wr(16'hff70, 8'h4c);
        partner.send_frame(frame(8'h3c, 1'b1, 2'h0), 9, 32);
        partner.send_frame(frame(8'h5a, 1'b1, 2'h0), 9, 32);
        repeat (40) @(posedge clk_sys);
        #1;
        rchk(16'hff71, 8'h01);
        rchk(16'hff74, 8'h5a);
        for (int k = 0; k < 3; k++) begin
            wr(16'hff70, (k == 0) ? 8'h78 : (k == 1) ? 8'h58 : 8'h48);
            f = frame(8'ha5, 1'b1, (k == 0) ? 2'h3 : 2'h0);
            f[8] = (k == 0) ? ~f[8] : (k == 1);
            partner.send_frame(f, 10, 32);
            repeat (40) @(posedge clk_sys);
            #1;
            rchk(16'hff71, (k == 0) ? 8'h04 : {6'h0, k == 2, 1'b0});
            rchk(16'hff74, 8'ha5);
        end
    endtask

    // External pin source: sixteen pin periods per bit
    task automatic t_ext_baud();
        logic [11:0] got;
        wr(16'hff73, 8'h80);
        wr(16'hff70, 8'h88);
        extRun = 1'b1;
        fork
            partner.grab_frame(got, 64);
            wr(16'hff74, 8'h96);
        join
        chk(got, frame(8'h96, 1'b1, 2'h0));
        extRun = 1'b0;
        wr(16'hff70, 8'h00);
    endtask

    // Clocked mode: select gating, period, order, idle level
    task automatic t_three_wire();
        logic [7:0] got;
        int c;
        c = 0;
        wr(16'hff73, 8'h10);
        slaveSelectPin = 1'b1;
        wr(16'hff72, 8'hc3);
        wr(16'hff74, 8'hb4);
        repeat (20) @(posedge clk_sys);
        #1;
        chk(serialClockPinOut, 1'b0);
        chk(serialOutOe, 1'b0);
        chk(serialClockPinOe, 1'b1);
        slaveSelectPin = 1'b0;
        fork
            partner.shift_slave(8'h6d, 1'b0, got);
            begin
                partner.wait_lvl(1'b1);
                while (serialClockPinOut !== 1'b0 && c < 50) begin
                    @(posedge clk_sys);
                    c++;
                end
                while (serialClockPinOut !== 1'b1 && c < 50) begin
                    @(posedge clk_sys);
                    c++;
                end
            end
        join
        chk(c[11:0], 12'h008);
        chk(got, 8'hb4);
        repeat (10) @(posedge clk_sys);
        #1;
        rchk(16'hff74, 8'h6d);
        chk(serialClockPinOut, 1'b0);
        wr(16'hff72, 8'h87);
        fork
            partner.shift_slave(8'h2e, 1'b1, got);
            wr(16'hff74, 8'h71);
        join
        chk(got, 8'h71);
        repeat (10) @(posedge clk_sys);
        #1;
        rchk(16'hff74, 8'h2e);
        wr(16'hff72, 8'h82);
        chk(serialClockPinOut, 1'b1);
        // Clock from the pin, started only once the transfer is armed
        wr(16'hff72, 8'h81);
        chk(serialClockPinOe, 1'b0);
        wr(16'hff74, 8'h3a);
        extRun = 1'b1;
        partner.shift_slave(8'hc5, 1'b0, got);
        extRun = 1'b0;
        chk(got, 8'h3a);
        repeat (10) @(posedge clk_sys);
        #1;
        rchk(16'hff74, 8'hc5);
        wr(16'hff72, 8'h00);
        chk(serialClockPinOe, 1'b0);
    endtask

    // Reset for three cycles, then the scenarios
    initial begin
        repeat (3) @(posedge clk_sys);
        #1;
        rstn = 1'b1;
        @(posedge clk_sys);
        #1;
        t_regs();
        t_async_tx();
        t_async_rx();
        t_ext_baud();
        t_three_wire();
        tally_and_finish();
    end
endmodule
